/* core/astg_gate.sv */
// astg_gate.sv - acquisition start trigger gate in front of frame start.
// assumes: one 250 MHz clock, wishbone master on the same clock,
// trigger lines asynchronous, internal frame request on ref_clk.
//
// Operation
// R1 - enabled gate starts waiting, discards frame triggers
// R2 - acquisition trigger opens frame triggers, one exposure each
// R3 - count accepted frames, return at programmed burst
// R4 - host must give fresh acquisition trigger afterward
// R5 - two-valued enable; burst return only when on
// R6 - enable off: acquisition starts generated internally
// R7 - software command counts as one acquisition trigger
// R8 - line one or two sourced triggers
// R9 - rising or falling edge select per trigger
// R10 - burst length only 1 through 255
// R11 - single frame mode: one frame, burst ignored
// R12 - host should choose continuous mode when enabled
// R13 - separate settings per trigger, selector picks target
// R14 - discarded triggers don't count; cleared each burst
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

`include "astg_map.svh"

module astg_gate
    import astg_pkg::*;
(
    input wire logic ref_clk,          // 250 MHz
    input wire logic sys_rst,          // async, active high
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // trigger input pins
    input wire logic line1_in,
    input wire logic line2_in,
    // internal frame request when frame triggering is off
    input wire logic int_frame_req,
    // results
    output logic exposure_start,
    output logic frame_discard,
    output logic acq_waiting
);

    // -----------------------------------------------------------------------
    // decode helpers
    // -----------------------------------------------------------------------

    // one trigger's event from its source and edge setting
    function automatic logic trig_hit(input astg_trig_cfg_t cfg, input logic sw,
                                      input logic [1:0] rise, input logic [1:0] fall);
        logic [1:0] edg;
        edg = cfg.falling ? fall : rise;
        case (cfg.src)
            ASTG_SRC_SOFT: trig_hit = sw;
            ASTG_SRC_LINE1: trig_hit = edg[0];
            ASTG_SRC_LINE2: trig_hit = edg[1];
            default: trig_hit = 1'b0;
        endcase
    endfunction

    // settings word from the bus, low lane
    function automatic astg_trig_cfg_t cfg_from_bus(input logic [31:0] d);
        astg_trig_cfg_t c;
        c.mode_on = d[`ASTG_CFG_MODE_BIT];
        c.src = astg_src_t'(d[`ASTG_CFG_SRC_LSB +: 2]);
        c.falling = d[`ASTG_CFG_EDGE_BIT];
        cfg_from_bus = c;
    endfunction

    // -----------------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------------
    logic ack_q;                   // bus answer flag
    logic [31:0] rdata_q;          // captured read word
    logic wr_go;                   // write takes effect this edge
    logic sel_frame_q;             // selector: 0 acquisition, 1 frame
    logic single_q;                // acquisition mode single frame
    astg_trig_cfg_t acq_cfg_q;     // acquisition start settings
    astg_trig_cfg_t frm_cfg_q;     // frame start settings
    astg_trig_cfg_t sel_cfg;       // settings the selector names
    logic [7:0] burst_len_q;       // frames per burst
    logic sw_acq_q;                // software acquisition pulse
    logic sw_frm_q;                // software frame pulse
    logic [1:0] line_raw;          // pins as a vector
    logic [1:0] sync1_q;           // first synchroniser stage
    logic [1:0] sync2_q;           // second synchroniser stage
    logic [1:0] line_prev_q;       // delayed for edge finding
    logic [1:0] line_rise;         // rising edges, one cycle
    logic [1:0] line_fall;         // falling edges, one cycle
    logic acq_hit;                 // external acquisition trigger
    logic frm_hit;                 // frame trigger from any source
    logic acq_on_prev_q;           // enable seen last cycle
    astg_state_t state_q;          // gate state
    logic [7:0] cnt_q;             // accepted frames in burst
    logic [7:0] burst_limit;       // effective burst length
    logic accept;                  // frame trigger taken
    logic burst_done;              // last frame of burst
    astg_status_t status;          // status word

    // -----------------------------------------------------------------------
    // wishbone slave
    // -----------------------------------------------------------------------

    // answer one cycle after request, drop the cycle after
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
        end
    end

    // write lands on the edge where the master sees ack
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

    assign wb_ack_o = ack_q;

    // R13 selector names which bank the bus sees
    assign sel_cfg = sel_frame_q ? frm_cfg_q : acq_cfg_q;

    // read word captured with ack; unmapped reads as zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 32'h0;
        end else if (wb_cyc_i & wb_stb_i & ~ack_q) begin
            rdata_q <= 32'h0;
            case (wb_adr_i)
                `ASTG_OFS_CTRL: begin
                    rdata_q[`ASTG_CTRL_SEL_BIT] <= sel_frame_q;
                    rdata_q[`ASTG_CTRL_SINGLE_BIT] <= single_q;
                end
                `ASTG_OFS_TRIG_CFG: begin
                    rdata_q[`ASTG_CFG_MODE_BIT] <= sel_cfg.mode_on;
                    rdata_q[`ASTG_CFG_SRC_LSB +: 2] <= sel_cfg.src;
                    rdata_q[`ASTG_CFG_EDGE_BIT] <= sel_cfg.falling;
                end
                `ASTG_OFS_FRM_COUNT: begin
                    rdata_q[7:0] <= burst_len_q;
                end
                `ASTG_OFS_STATUS: begin
                    rdata_q[9:0] <= status;
                end
                default: begin
                    rdata_q <= 32'h0;
                end
            endcase
        end
    end

    assign wb_dat_o = rdata_q;

    // -----------------------------------------------------------------------
    // control registers
    // -----------------------------------------------------------------------

    // selector and acquisition mode
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_frame_q <= 1'b0;
            single_q <= 1'b0;
        end else if (wr_go && wb_adr_i == `ASTG_OFS_CTRL) begin
            sel_frame_q <= wb_dat_i[`ASTG_CTRL_SEL_BIT];
            single_q <= wb_dat_i[`ASTG_CTRL_SINGLE_BIT];
        end
    end

    // R13 settings write goes only to the selected bank
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acq_cfg_q <= '0;
            frm_cfg_q <= '0;
        end else if (wr_go && wb_adr_i == `ASTG_OFS_TRIG_CFG) begin
            // a source code outside the list would never fire
            if (sel_frame_q) begin
                frm_cfg_q <= cfg_from_bus(wb_dat_i);
            end else begin
                acq_cfg_q <= cfg_from_bus(wb_dat_i);
            end
        end
    end

    // R10 burst length: zero is refused, old value kept
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            burst_len_q <= `ASTG_RST_FRM_COUNT;
        end else if (wr_go && wb_adr_i == `ASTG_OFS_FRM_COUNT) begin
            if (wb_dat_i[7:0] >= `ASTG_FRM_COUNT_MIN) begin
                burst_len_q <= wb_dat_i[7:0];
            end
        end
    end

    // R7 software command, routed by the selector
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_acq_q <= 1'b0;
            sw_frm_q <= 1'b0;
        end else begin
            sw_acq_q <= wr_go && wb_adr_i == `ASTG_OFS_SW_TRIG
                        && wb_dat_i[`ASTG_SW_FIRE_BIT] && !sel_frame_q;
            sw_frm_q <= wr_go && wb_adr_i == `ASTG_OFS_SW_TRIG
                        && wb_dat_i[`ASTG_SW_FIRE_BIT] && sel_frame_q;
        end
    end

    // -----------------------------------------------------------------------
    // input lines
    // -----------------------------------------------------------------------
    assign line_raw = {line2_in, line1_in};

    // R8 two-flop synchroniser and edge finder per line
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_line
            // stage one is read by stage two only
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    line_prev_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= line_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    line_prev_q[gi] <= sync2_q[gi];
                end
            end
            // R9 both edges, picked later by setting
            assign line_rise[gi] = sync2_q[gi] & ~line_prev_q[gi];
            assign line_fall[gi] = ~sync2_q[gi] & line_prev_q[gi];
        end
    endgenerate

    // -----------------------------------------------------------------------
    // trigger events
    // -----------------------------------------------------------------------

    // R9 acquisition trigger from its own source and edge
    assign acq_hit = trig_hit(acq_cfg_q, sw_acq_q, line_rise, line_fall);

    // frame trigger: own source when on, internal request when off
    assign frm_hit = frm_cfg_q.mode_on ?
                     trig_hit(frm_cfg_q, sw_frm_q, line_rise, line_fall) :
                     int_frame_req;

    // R11 single frame caps burst at one
    assign burst_limit = single_q ? 8'h01 : burst_len_q;

    // R2 frame triggers pass only while waiting for frames
    assign accept = frm_hit && state_q == ASTG_WAIT_FRAME;

    // R5 burst return only with the enable on
    assign burst_done = accept && acq_cfg_q.mode_on && (cnt_q + 8'h01 == burst_limit);

    // -----------------------------------------------------------------------
    // gate state
    // -----------------------------------------------------------------------

    // enable edge history, restarts the wait when turned on
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acq_on_prev_q <= 1'b0;
        end else begin
            acq_on_prev_q <= acq_cfg_q.mode_on;
        end
    end

    // acquisition status machine
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ASTG_WAIT_ACQ;
        end else if (acq_cfg_q.mode_on && !acq_on_prev_q) begin
            // R1 enabling puts the gate back to waiting
            state_q <= ASTG_WAIT_ACQ;
        end else begin
            case (state_q)
                ASTG_WAIT_ACQ: begin
                    // R6 with enable off the start is internal
                    if (!acq_cfg_q.mode_on) begin
                        state_q <= ASTG_WAIT_FRAME;
                    // R2 external start opens the frame gate
                    end else if (acq_hit) begin
                        state_q <= ASTG_WAIT_FRAME;
                    end
                end
                ASTG_WAIT_FRAME: begin
                    // R3 burst complete, wait for next start
                    if (burst_done) begin
                        state_q <= ASTG_WAIT_ACQ;
                    end
                end
                default: begin
                    state_q <= ASTG_WAIT_ACQ;
                end
            endcase
        end
    end

    // R14 burst counter: only accepted frames, cleared per burst
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 8'h00;
        end else if (state_q == ASTG_WAIT_ACQ) begin
            // held at zero until a new burst begins
            cnt_q <= 8'h00;
        end else if (burst_done) begin
            cnt_q <= 8'h00;
        end else if (accept && acq_cfg_q.mode_on) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // -----------------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------------

    // R2 one exposure per accepted frame trigger
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exposure_start <= 1'b0;
            frame_discard <= 1'b0;
        end else begin
            exposure_start <= accept;
            // R1 triggers while waiting are dropped
            frame_discard <= frm_hit && state_q == ASTG_WAIT_ACQ;
        end
    end

    // status assembled from state and counter
    assign status.wait_acq = state_q == ASTG_WAIT_ACQ;
    assign status.wait_frame = state_q == ASTG_WAIT_FRAME;
    assign status.burst_cnt = cnt_q;

    // waiting flag straight from the state register
    assign acq_waiting = status.wait_acq;

endmodule // astg_gate

/* core/astg_map.svh */
// astg_map.svh - register offsets, field positions and reset values of the
// acquisition start trigger gate.
// assumes: 32-bit classic wishbone, one aligned word per register.
`ifndef ASTG_MAP_SVH
`define ASTG_MAP_SVH

// ---------------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------------
`define ASTG_OFS_CTRL      8'h00
`define ASTG_OFS_TRIG_CFG  8'h04
`define ASTG_OFS_FRM_COUNT 8'h08
`define ASTG_OFS_SW_TRIG   8'h0C
`define ASTG_OFS_STATUS    8'h10

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define ASTG_CTRL_SEL_BIT    0
`define ASTG_CTRL_SINGLE_BIT 1
`define ASTG_CFG_MODE_BIT    0
`define ASTG_CFG_SRC_LSB     1
`define ASTG_CFG_EDGE_BIT    3
`define ASTG_SW_FIRE_BIT     0

// ---------------------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------------------
`define ASTG_RST_FRM_COUNT 8'h01
`define ASTG_FRM_COUNT_MIN 8'h01

`endif

/* core/astg_pkg.sv */
// astg_pkg.sv - types shared by the acquisition start trigger gate.
// assumes: source and state codes are set here; the register map supplies offsets and fields.
package astg_pkg;

    // trigger source selection
    typedef enum logic [1:0] {
        ASTG_SRC_SOFT  = 2'h0,
        ASTG_SRC_LINE1 = 2'h1,
        ASTG_SRC_LINE2 = 2'h2
    } astg_src_t;

    // per-trigger settings: mode, source, edge
    typedef struct packed {
        logic falling;
        astg_src_t src;
        logic mode_on;
    } astg_trig_cfg_t;

    // gate states, gray along waiting -> active
    typedef enum logic [1:0] {
        ASTG_WAIT_ACQ   = 2'h0,
        ASTG_WAIT_FRAME = 2'h1
    } astg_state_t;

    // block status seen by software and pins
    typedef struct packed {
        logic [7:0] burst_cnt;
        logic wait_frame;
        logic wait_acq;
    } astg_status_t;

endpackage

/* sim/astg_gate_chk.sv */
// astg_gate_chk.sv - port-level assertions for the trigger gate.
// assumes: int_frame_req is the live frame trigger source, and the bench
// holds it low whenever frame trigger mode is on.
`timescale 1ns/1ps

module astg_gate_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic int_frame_req,
    input wire logic exposure_start,
    input wire logic frame_discard,
    input wire logic acq_waiting
);
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_discard_waits: assert property (frame_discard |-> $past(acq_waiting))
        else $error("frame dropped outside waiting state");
    chk_expose_active: assert property (exposure_start |-> !$past(acq_waiting))
        else $error("exposure while waiting for acquisition start");
    chk_req_expose: assert property (int_frame_req && !acq_waiting |=> exposure_start)
        else $error("frame request not turned into exposure");
    chk_req_discard: assert property (int_frame_req && acq_waiting |=> frame_discard)
        else $error("frame request while waiting not discarded");
    chk_one_outcome: assert property (!(exposure_start && frame_discard))
        else $error("frame both accepted and discarded");
    chk_return_cause: assert property ($rose(acq_waiting) |->
        exposure_start || $past(exposure_start) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
        else $error("return to waiting without burst end or write");
    chk_ack_next: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("bus answer late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer longer than one cycle");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h10 |->
        wb_dat_o == 32'h0)
        else $error("unmapped read not zero");

    // main scenarios reached
    cover property (exposure_start);
    cover property (frame_discard);
    cover property ($rose(acq_waiting));
endmodule // astg_gate_chk

bind astg_gate astg_gate_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_frame_req(int_frame_req),
    .exposure_start(exposure_start), .frame_discard(frame_discard),
    .acq_waiting(acq_waiting));

/* sim/astg_line_src.sv */
// astg_line_src.sv - external trigger source on the two input lines.
// assumes: driven pins idle low; each flip request toggles one line.
`timescale 1ns/1ps

module astg_line_src (
    input wire logic ref_clk,
    input wire logic [1:0] flip,
    output logic line1_in,
    output logic line2_in
);
    logic [1:0] lvl_q = 2'b00; // actively driven, so never left floating

    // ------------------------------------------------------------------
    // line toggling
    // ------------------------------------------------------------------
    // edge per request
    always @(posedge ref_clk) begin
        lvl_q <= lvl_q ^ flip;
    end

    assign line1_in = lvl_q[0];
    assign line2_in = lvl_q[1];
endmodule // astg_line_src

/* sim/tb_top.sv */
// tb_top.sv - self-checking bench for the trigger gate.
// assumes: int_frame_req drives frames; frame trigger mode goes on only
// at the very end, and only with a software frame trigger.
`timescale 1ns/1ps
`include "astg_map.svh"

module tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, line1_in, line2_in, exposure_start, frame_discard, acq_waiting;
    logic int_frame_req = 1'b0;
    logic [1:0] flip = 2'b00;
    int bad_count = 0, compares = 0, n_exp = 0, n_disc = 0, n;
    int srcs [3] = '{0, 1, 2}; // software, line one, line two
    int falls [3] = '{0, 0, 1}; // only line two uses the falling edge

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    astg_gate u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line1_in(line1_in),
        .line2_in(line2_in), .int_frame_req(int_frame_req), .exposure_start(exposure_start),
        .frame_discard(frame_discard), .acq_waiting(acq_waiting));

    astg_line_src u_src (.ref_clk(ref_clk), .flip(flip), .line1_in(line1_in),
        .line2_in(line2_in));

    // pulse tallies, sampled before each edge lands
    always @(posedge ref_clk) begin
        n_exp <= n_exp + int'(exposure_start === 1'b1);
        n_disc <= n_disc + int'(frame_discard === 1'b1);
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one classic cycle, waits for the answer under a bound
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (i == 16) begin
            bad_count++;
            complete_run();
        end
    endtask

    // expected status word: bit0 waiting, bit1 active, count above
    function automatic logic [31:0] stat_word(input logic wait_acq, input logic [7:0] cnt);
        stat_word = {22'h0, cnt, ~wait_acq, wait_acq};
    endfunction

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        check(rd, exp);
    endtask

    // bounded wait for the waiting flag, a miss ends the run
    task automatic wait_level(input logic exp);
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (acq_waiting === exp) break;
        end
        check(acq_waiting, exp);
        if (acq_waiting !== exp) complete_run();
    endtask

    // k back-to-back frame requests, then tally the outcomes
    task automatic frames(input int k, input int ne, input int nd);
        int e0, d0;
        e0 = n_exp;
        d0 = n_disc;
        @(posedge ref_clk);
        int_frame_req <= 1'b1;
        repeat (k) @(posedge ref_clk);
        int_frame_req <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check(32'(n_exp - e0), 32'(ne));
        check(32'(n_disc - d0), 32'(nd));
    endtask

    task automatic fire(input int src);
        if (src == 0) begin
            wb(1'b1, `ASTG_OFS_SW_TRIG, 32'h1);
        end else begin
            @(posedge ref_clk);
            flip <= 2'(1 << (src - 1));
            @(posedge ref_clk);
            flip <= 2'b00;
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'he2534db4));
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_level(1'b0);
        frames(3, 3, 0);
        rdchk(`ASTG_OFS_STATUS, stat_word(1'b0, 8'h00));
        rdchk(`ASTG_OFS_CTRL, 32'h0);
        rdchk(`ASTG_OFS_TRIG_CFG, 32'h0);
        rdchk(`ASTG_OFS_FRM_COUNT, 32'(`ASTG_RST_FRM_COUNT));
        rdchk(`ASTG_OFS_SW_TRIG, 32'h0);
        rdchk(8'h14, 32'h0);
        wb(1'b1, `ASTG_OFS_FRM_COUNT, 32'h0);
        rdchk(`ASTG_OFS_FRM_COUNT, 32'h1);
        wb(1'b1, `ASTG_OFS_TRIG_CFG, 32'h1);
        wb(1'b1, `ASTG_OFS_CTRL, 32'h1);
        rdchk(`ASTG_OFS_TRIG_CFG, 32'h0);
        wb(1'b1, `ASTG_OFS_CTRL, 32'h0); // continuous mode kept
        rdchk(`ASTG_OFS_TRIG_CFG, 32'h1);
        for (int i = 0; i < 3; i++) begin
            n = (i == 0) ? 255 : 1 + int'($urandom % 7);
            wb(1'b1, `ASTG_OFS_TRIG_CFG, 32'(1 | (srcs[i] << 1) | (falls[i] << 3)));
            wb(1'b1, `ASTG_OFS_FRM_COUNT, 32'(n));
            rdchk(`ASTG_OFS_FRM_COUNT, 32'(n));
            wait_level(1'b1);
            frames(1, 0, 1);
            rdchk(`ASTG_OFS_STATUS, stat_word(1'b1, 8'h00));
            if (falls[i] == 1) begin
                fire(srcs[i]);
                repeat (8) @(posedge ref_clk);
                check(acq_waiting, 1'b1);
            end
            fire(srcs[i]);
            wait_level(1'b0);
            frames(1, 1, 0);
            rdchk(`ASTG_OFS_STATUS, stat_word(n == 1, 8'(n > 1)));
            frames(n, n - 1, 1);
            check(acq_waiting, 1'b1);
        end
        wb(1'b1, `ASTG_OFS_TRIG_CFG, 32'h1);
        wb(1'b1, `ASTG_OFS_CTRL, 32'h2);
        wb(1'b1, `ASTG_OFS_FRM_COUNT, 32'h3);
        fire(0);
        wait_level(1'b0);
        frames(3, 1, 2);
        wb(1'b1, `ASTG_OFS_TRIG_CFG, 32'h0);
        wait_level(1'b0);
        frames(2, 2, 0);
        // frame bank on with software source; int_frame_req stays low here
        wb(1'b1, `ASTG_OFS_CTRL, 32'h1); // continuous, frame bank
        wb(1'b1, `ASTG_OFS_TRIG_CFG, 32'h1);
        rdchk(`ASTG_OFS_TRIG_CFG, 32'h1);
        n = n_exp;
        wb(1'b1, `ASTG_OFS_SW_TRIG, 32'h1);
        repeat (4) @(posedge ref_clk);
        check(32'(n_exp - n), 32'h1);
        complete_run();
    end
endmodule // tb_top
